/* hw/dpc_counter.sv */
// Debounced pulse counter on one contact input, with overflow and cyclic
// telegram strobes. Assumes configuration ports hold steady while counting.
//
// Functional notes
// - The contact is read as normally closed or normally open per config.
// - With no function selected the input is ignored; counter mode counts.
// - A count pulse comes on press, on release, or on both edges.
// - Each count pulse adds the configured step of 1 to 255.
// - Counting and the sent value use a width of one, two or four bytes.
// - After reset or failure the start value is loaded before counting.
// - An increment taking the count above the end value is an overflow.
// - On overflow a telegram of none, one bit or one byte is sent.
// - With cyclic sending on, the count is sent at the configured period.
// - The contact is debounced with a 10 ms to 150 ms filter time.
`timescale 1ns/100ps
`include "dpc_params.svh"
module dpc_counter #(
    parameter int MS_CYCLES = `DPC_MS_CYCLES,
    parameter int S_MS      = `DPC_S_MS
) (
    // Clock and reset
    input  logic                 sys_clk,
    input  logic                 arst_n,
    // Contact and failure
    input  logic                 contact_raw,
    input  logic                 fail_load,
    // Configuration
    input  dpc_pkg::dpc_mode_t   op_mode,
    input  logic                 contact_nc,
    input  dpc_pkg::dpc_edge_t   count_on,
    input  logic [7:0]           step_size,
    input  dpc_pkg::dpc_size_t   count_size,
    input  logic [31:0]          start_value,
    input  logic [31:0]          end_value,
    input  logic                 cyc_enable,
    input  logic [15:0]          cyc_period_s,
    input  dpc_pkg::dpc_ovf_t    ovf_len,
    input  logic [7:0]           ovf_value,
    input  logic [2:0]           deb_sel,
    // Status and telegrams
    output logic                 contact_pressed,
    output logic [31:0]          count_value,
    output logic                 count_tx_valid,
    output logic [31:0]          count_tx_data,
    output logic                 ovf_tx_valid,
    output logic [7:0]           ovf_tx_data
);

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
    localparam logic [9:0]  S_LAST  = 10'(S_MS - 1);

    generate
        if (MS_CYCLES < 2 || MS_CYCLES > 65536) begin : g_chk_ms
            $error("dpc_counter: MS_CYCLES out of range");
        end
        if (S_MS < 1 || S_MS > 1024) begin : g_chk_s
            $error("dpc_counter: S_MS out of range");
        end
    endgenerate

    dpc_pkg::dpc_state_t st_ff;
    dpc_pkg::dpc_state_t nxt_st;

    logic [7:0]  deb_limit;
    logic        deb_level;
    logic        pressed;
    logic        press_ev;
    logic        rel_ev;
    logic        pulse;
    logic        sec_tick;
    logic [31:0] mask;
    logic [31:0] start_m;
    logic [31:0] end_m;
    logic [32:0] sum;
    logic        exceed;

    // ****************************************************************
    // Debounce
    // ****************************************************************
    always_comb begin
        case (deb_sel)
            3'h0:    deb_limit = `DPC_DEB_10MS;
            3'h1:    deb_limit = `DPC_DEB_20MS;
            3'h2:    deb_limit = `DPC_DEB_30MS;
            3'h3:    deb_limit = `DPC_DEB_40MS;
            3'h4:    deb_limit = `DPC_DEB_50MS;
            3'h5:    deb_limit = `DPC_DEB_70MS;
            3'h6:    deb_limit = `DPC_DEB_100MS;
            default: deb_limit = `DPC_DEB_150MS;
        endcase
    end

    dpc_debounce #(
        .W       (8)
    ) u_deb (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (st_ff.ms_tick),
        .raw     (contact_raw ^ contact_nc),
        .limit   (deb_limit),
        .level   (deb_level)
    );

    // ****************************************************************
    // Edges and arithmetic
    // ****************************************************************
    // Polarity folded in ahead of the filter, so its reset level means
    // released for either contact type: no false edge after reset
    assign pressed  = deb_level;
    assign press_ev = pressed & ~st_ff.prs_prev;
    assign rel_ev   = ~pressed & st_ff.prs_prev;

    always_comb begin
        case (count_on)
            dpc_pkg::DPC_ON_PRESS:   pulse = press_ev;
            dpc_pkg::DPC_ON_RELEASE: pulse = rel_ev;
            dpc_pkg::DPC_ON_BOTH:    pulse = press_ev | rel_ev;
            default:                 pulse = 1'b0;
        endcase
        if (op_mode != dpc_pkg::DPC_MODE_COUNTER ||
            st_ff.phase != dpc_pkg::DPC_ST_RUN) begin
            pulse = 1'b0;
        end
    end

    always_comb begin
        case (count_size)
            dpc_pkg::DPC_SIZE_1B: mask = `DPC_MASK_1B;
            dpc_pkg::DPC_SIZE_2B: mask = `DPC_MASK_2B;
            default:              mask = `DPC_MASK_4B;
        endcase
    end

    assign start_m = start_value & mask;
    assign end_m   = end_value & mask;
    // Wrap past the width also counts, since the sum is taken wide
    assign sum     = {1'b0, st_ff.count} + {25'h0, step_size};
    assign exceed  = sum > {1'b0, end_m};

    assign sec_tick = st_ff.ms_tick && st_ff.sub_s == S_LAST;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.ms_tick = 1'b0;
        nxt_st.cnt_vld = 1'b0;
        nxt_st.ovf_vld = 1'b0;
        nxt_st.ovf_ev  = 1'b0;
        nxt_st.prs_prev = pressed;
        if (st_ff.ms_cnt == MS_LAST) begin
            nxt_st.ms_cnt  = 16'h0;
            nxt_st.ms_tick = 1'b1;
        end else begin
            nxt_st.ms_cnt = st_ff.ms_cnt + 16'h1;
        end
        if (st_ff.ms_tick) begin
            nxt_st.sub_s = (st_ff.sub_s == S_LAST) ? 10'h0
                                                   : st_ff.sub_s + 10'h1;
        end
        case (st_ff.phase)
            dpc_pkg::DPC_ST_INIT: begin
                nxt_st.count = start_m;
                nxt_st.phase = dpc_pkg::DPC_ST_RUN;
            end
            dpc_pkg::DPC_ST_RUN: begin
                if (pulse && exceed) begin
                    nxt_st.ovf_ev = 1'b1;
                    nxt_st.count  = start_m;
                    if (ovf_len != dpc_pkg::DPC_OVF_NONE) begin
                        nxt_st.ovf_vld = 1'b1;
                        nxt_st.ovf_data =
                            (ovf_len == dpc_pkg::DPC_OVF_BIT)
                            ? {7'h0, ovf_value[0]} : ovf_value;
                    end
                end else if (pulse) begin
                    nxt_st.count = sum[31:0] & mask;
                end
            end
            default: nxt_st.phase = dpc_pkg::DPC_ST_INIT;
        endcase
        // Period zero sends nothing rather than flooding the bus
        if (!cyc_enable || cyc_period_s == 16'h0) begin
            nxt_st.sec_cnt = 16'h0;
        end else if (sec_tick) begin
            if (st_ff.sec_cnt + 16'h1 >= cyc_period_s) begin
                nxt_st.sec_cnt  = 16'h0;
                nxt_st.cnt_vld  = 1'b1;
                nxt_st.cnt_data = st_ff.count & mask;
            end else begin
                nxt_st.sec_cnt = st_ff.sec_cnt + 16'h1;
            end
        end
        if (fail_load) begin
            nxt_st.phase = dpc_pkg::DPC_ST_INIT;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff          <= '0;
            st_ff.phase    <= dpc_pkg::DPC_ST_INIT;
            st_ff.count    <= `DPC_RST_COUNT;
            st_ff.cnt_data <= `DPC_RST_COUNT;
            st_ff.ovf_data <= `DPC_RST_BYTE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign contact_pressed = st_ff.prs_prev;
    assign count_value     = st_ff.count;
    assign count_tx_valid  = st_ff.cnt_vld;
    assign count_tx_data   = st_ff.cnt_data;
    assign ovf_tx_valid    = st_ff.ovf_vld;
    assign ovf_tx_data     = st_ff.ovf_data;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    polarity_a: assert property (press_ev |->
        $past(contact_raw) != $past(contact_nc))
        else $error("Press pulse without pressed contact");

    ignore_mode_a: assert property (
        op_mode == dpc_pkg::DPC_MODE_NONE && !fail_load &&
        st_ff.phase == dpc_pkg::DPC_ST_RUN |=> $stable(st_ff.count))
        else $error("Count moved with no function selected");

    release_only_a: assert property (
        count_on == dpc_pkg::DPC_ON_RELEASE && pulse |->
        st_ff.prs_prev && !pressed)
        else $error("Release pulse without release edge");

    step_add_a: assert property (pulse && !exceed && !fail_load
        |=> st_ff.count == ($past(sum[31:0]) & $past(mask)))
        else $error("Count did not advance by the step");

    width_1b_a: assert property (
        count_size == dpc_pkg::DPC_SIZE_1B && $stable(count_size)
        && !$past(st_ff.phase == dpc_pkg::DPC_ST_INIT)
        && $past(count_size == dpc_pkg::DPC_SIZE_1B)
        && st_ff.count[31:8] == 24'h0
        |=> st_ff.count[31:8] == 24'h0)
        else $error("One byte count grew past eight bits");

    init_load_a: assert property (
        st_ff.phase == dpc_pkg::DPC_ST_INIT && !fail_load
        |=> st_ff.count == $past(start_m) &&
            st_ff.phase == dpc_pkg::DPC_ST_RUN)
        else $error("Start value not loaded");

    exceed_a: assert property (st_ff.ovf_ev |->
        $past(sum) > {1'b0, $past(end_m)})
        else $error("Overflow without passing the end value");

    ovf_tel_a: assert property (
        st_ff.ovf_ev |-> st_ff.ovf_vld ==
        ($past(ovf_len) != dpc_pkg::DPC_OVF_NONE))
        else $error("Overflow telegram does not match its length");

    ovf_bit_a: assert property (
        st_ff.ovf_vld && $past(ovf_len) == dpc_pkg::DPC_OVF_BIT
        |-> st_ff.ovf_data == {7'h0, $past(ovf_value[0])})
        else $error("One bit overflow telegram carries wrong value");

    cyclic_a: assert property (st_ff.cnt_vld |->
        $past(cyc_enable) && $past(sec_tick)
        && st_ff.cnt_data == ($past(st_ff.count) & $past(mask)))
        else $error("Cyclic telegram without its period");

    cyc_gap_a: assert property (
        st_ff.cnt_vld ##1 !st_ff.cnt_vld |-> !st_ff.cnt_vld [*8])
        else $error("Cyclic telegrams too close together");

    reload_a: assert property (st_ff.ovf_ev && !$past(fail_load)
        |-> st_ff.count == $past(start_m))
        else $error("Start value not reloaded after overflow");

    cnt_pulse_c: cover property (pulse && !exceed);
    ovf_byte_c:  cover property (st_ff.ovf_vld &&
        $past(ovf_len) == dpc_pkg::DPC_OVF_BYTE);
    cyc_send_c:  cover property (st_ff.cnt_vld);
    fail_c:      cover property (fail_load ##1 !fail_load ##[1:300] pulse);

endmodule : dpc_counter

/* hw/dpc_params.svh */
// Constants of the debounced pulse counter: timing, debounce table, resets.
// Assumes a single 25 MHz system clock; included by bare name.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define DPC_CLK_NS      40
`define DPC_MS_NS       1000000
`define DPC_MS_CYCLES   (`DPC_MS_NS / `DPC_CLK_NS)
`define DPC_S_MS        1000
`define DPC_CYC_DEF_S   16'h001e

// ****************************************************************
// Debounce filter times in ms
// ****************************************************************
`define DPC_DEB_10MS    8'h0a
`define DPC_DEB_20MS    8'h14
`define DPC_DEB_30MS    8'h1e
`define DPC_DEB_40MS    8'h28
`define DPC_DEB_50MS    8'h32
`define DPC_DEB_70MS    8'h46
`define DPC_DEB_100MS   8'h64
`define DPC_DEB_150MS   8'h96

// ****************************************************************
// Count widths and reset values
// ****************************************************************
`define DPC_MASK_1B     32'h0000_00ff
`define DPC_MASK_2B     32'h0000_ffff
`define DPC_MASK_4B     32'hffff_ffff
`define DPC_RST_COUNT   32'h0000_0000
`define DPC_RST_BYTE    8'h00

`endif

/* hw/dpc_pkg.sv */
// Types of the debounced pulse counter.
// Assumes dpc_params.svh holds every number.
package dpc_pkg;

    // ****************************************************************
    // Configuration encodings
    // ****************************************************************
    typedef enum logic [1:0] {DPC_MODE_NONE, DPC_MODE_COUNTER,
                              DPC_MODE_OTHER} dpc_mode_t;
    typedef enum logic [1:0] {DPC_ON_PRESS, DPC_ON_RELEASE,
                              DPC_ON_BOTH} dpc_edge_t;
    typedef enum logic [1:0] {DPC_SIZE_1B, DPC_SIZE_2B,
                              DPC_SIZE_4B} dpc_size_t;
    typedef enum logic [1:0] {DPC_OVF_NONE, DPC_OVF_BIT,
                              DPC_OVF_BYTE} dpc_ovf_t;
    typedef enum logic {DPC_ST_INIT, DPC_ST_RUN} dpc_phase_t;

    // ****************************************************************
    // Top state
    // ****************************************************************
    typedef struct packed {
        dpc_phase_t  phase;
        logic [15:0] ms_cnt;
        logic        ms_tick;
        logic [9:0]  sub_s;
        logic [15:0] sec_cnt;
        logic        prs_prev;
        logic [31:0] count;
        logic        cnt_vld;
        logic [31:0] cnt_data;
        logic        ovf_vld;
        logic [7:0]  ovf_data;
        logic        ovf_ev;
    } dpc_state_t;

endpackage : dpc_pkg

/* hw/dpc_debounce.sv */
// Contact debounce filter counting millisecond ticks.
// Assumes raw is synchronous to sys_clk and tick is a one-cycle enable.
`timescale 1ns/100ps
module dpc_debounce #(
    parameter int W = 8
) (
    // Clock and reset
    input  logic         sys_clk,
    input  logic         arst_n,
    // Filter
    input  logic         tick,
    input  logic         raw,
    input  logic [W-1:0] limit,
    output logic         level
);

    typedef struct packed {
        logic         level;
        logic [W-1:0] cnt;
    } dpc_deb_t;

    dpc_deb_t st_ff;
    dpc_deb_t nxt_st;

    generate
        if (W < 2) begin : g_chk
            $error("dpc_debounce: W too small");
        end
    endgenerate

    // ****************************************************************
    // Filter
    // ****************************************************************
    // Any return to the held level restarts the wait, so bounce is lost
    always_comb begin
        nxt_st = st_ff;
        if (raw == st_ff.level) begin
            nxt_st.cnt = '0;
        end else if (tick) begin
            if (st_ff.cnt + W'(1) >= limit) begin
                nxt_st.level = raw;
                nxt_st.cnt   = '0;
            end else begin
                nxt_st.cnt = st_ff.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.level;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    deb_on_tick_a: assert property ($changed(st_ff.level) |->
        $past(tick) && $past(raw) == st_ff.level)
        else $error("Debounced level moved without a settled tick");

endmodule : dpc_debounce

/* verif/dpc_contact_model.sv */
// Contact model: a switch whose line bounces on every change of state.
// Assumes the bench moves pressed just after a rising clock edge.
`timescale 1ns/100ps
module dpc_contact_model (
    // Clock
    input  logic sys_clk,
    // Contact control
    input  logic pressed,
    input  logic nc_type,
    // Contact line
    output logic raw
);
    logic       state_ff = 1'b0;
    logic [3:0] bnc_ff   = 4'h0;

    // ****************************************************************
    // Bounce: the line chatters six cycles, far below any filter time
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (pressed != state_ff) begin
            state_ff <= pressed;
            bnc_ff   <= 4'h6;
        end else if (bnc_ff != 4'h0) begin
            bnc_ff <= bnc_ff - 4'h1;
        end
    end

    // Normally closed contact opens when pressed
    assign raw = state_ff ^ nc_type ^ bnc_ff[0];
endmodule : dpc_contact_model

/* verif/debounced_pulse_counter_input_test.sv */
// Self-checking bench of the debounced pulse counter.
// Assumes dpc_counter with 4-cycle ms and 4-ms seconds.
`timescale 1ns/100ps
`include "dpc_params.svh"
module debounced_pulse_counter_input_test;
    logic               sys_clk = 1'b0;
    logic               arst_n  = 1'b0;
    logic               pr      = 1'b0;
    logic               contact_raw;
    logic               fail_load = 1'b0;
    dpc_pkg::dpc_mode_t op_mode   = dpc_pkg::DPC_MODE_COUNTER;
    logic               contact_nc = 1'b0;
    dpc_pkg::dpc_edge_t count_on  = dpc_pkg::DPC_ON_PRESS;
    logic [7:0]         step_size = 8'h05;
    dpc_pkg::dpc_size_t count_size = dpc_pkg::DPC_SIZE_4B;
    logic [31:0]        start_value = 32'h0000_0003;
    logic [31:0]        end_value   = 32'hffff_ffff;
    logic               cyc_enable  = 1'b0;
    logic [15:0]        cyc_period_s = 16'h0001;
    dpc_pkg::dpc_ovf_t  ovf_len   = dpc_pkg::DPC_OVF_NONE;
    logic [7:0]         ovf_value = 8'ha3;
    logic [2:0]         deb_sel   = 3'h0;
    logic               contact_pressed;
    logic [31:0]        count_value;
    logic               count_tx_valid;
    logic [31:0]        count_tx_data;
    logic               ovf_tx_valid;
    logic [7:0]         ovf_tx_data;
    int                 err_count = 0;
    int                 check_count = 0;
    int                 ovf_seen = 0;
    int                 cyc_seen = 0;
    int                 cycles = 0;

    always #20 sys_clk = ~sys_clk;

    dpc_contact_model partner (.sys_clk(sys_clk), .pressed(pr),
        .nc_type(contact_nc), .raw(contact_raw));

    dpc_counter #(.MS_CYCLES(4), .S_MS(4)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .contact_raw(contact_raw),
        .fail_load(fail_load), .op_mode(op_mode), .contact_nc(contact_nc),
        .count_on(count_on), .step_size(step_size),
        .count_size(count_size), .start_value(start_value),
        .end_value(end_value), .cyc_enable(cyc_enable),
        .cyc_period_s(cyc_period_s), .ovf_len(ovf_len),
        .ovf_value(ovf_value), .deb_sel(deb_sel),
        .contact_pressed(contact_pressed), .count_value(count_value),
        .count_tx_valid(count_tx_valid), .count_tx_data(count_tx_data),
        .ovf_tx_valid(ovf_tx_valid), .ovf_tx_data(ovf_tx_data));

    // ****************************************************************
    // Strobe monitors and hang guard
    // ****************************************************************
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (ovf_tx_valid === 1'b1) ovf_seen = ovf_seen + 1;
        if (count_tx_valid === 1'b1) cyc_seen = cyc_seen + 1;
        if (cycles >= 8000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    // Filter time bounds the wait: 10 ticks of 4 cycles plus bounce
    task automatic act(input logic p);
        int i;
        pr = p;
        for (i = 0; i < 200 && contact_pressed !== p; i++) step(1);
        step(2);
        chk({31'h0, contact_pressed}, {31'h0, p});
    endtask : act

    task automatic click;
        act(1'b1);
        act(1'b0);
    endtask : click

    task automatic reload;
        fail_load = 1'b1;
        step(2);
        fail_load = 1'b0;
        step(2);
    endtask : reload

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_edges;
        int i;
        for (i = 0; i < 3; i++) begin
            count_on = dpc_pkg::dpc_edge_t'(i);
            reload();
            chk(count_value, 32'h3);
            act(1'b1);
            chk(count_value, (i == 1) ? 32'h3 : 32'h8);
            act(1'b0);
            chk(count_value, (i == 2) ? 32'hd : 32'h8);
        end
        count_on = dpc_pkg::DPC_ON_PRESS;
    endtask : t_edges

    // Count left at 0xd by the last edge scenario
    task automatic t_glitch_none;
        int i;
        pr = 1'b1;
        step(10);
        pr = 1'b0;
        step(80);
        chk(count_value, 32'hd);
        for (i = 0; i < 3; i += 2) begin
            op_mode = dpc_pkg::dpc_mode_t'(i);
            pr = 1'b1;
            step(80);
            pr = 1'b0;
            step(80);
            chk(count_value, 32'hd);
        end
        op_mode = dpc_pkg::DPC_MODE_COUNTER;
    endtask : t_glitch_none

    // Polarity swap on a released contact must raise no event
    task automatic t_nc;
        contact_nc = 1'b1;
        step(100);
        chk(count_value, 32'hd);
        reload();
        act(1'b1);
        chk({31'h0, contact_raw}, 32'h0);
        chk(count_value, 32'h8);
        act(1'b0);
        contact_nc = 1'b0;
        step(100);
    endtask : t_nc

    task automatic t_ovf;
        int i;
        int o0;
        count_size = dpc_pkg::DPC_SIZE_1B;
        start_value = 32'h5;
        end_value = 32'h8;
        step_size = 8'h02;
        for (i = 1; i < 4; i++) begin
            ovf_len = dpc_pkg::dpc_ovf_t'(i % 3);
            reload();
            o0 = ovf_seen;
            click();
            chk(count_value, 32'h7);
            click();
            chk(count_value, 32'h5);
            chk(ovf_seen - o0, (i < 3) ? 32'h1 : 32'h0);
            if (i < 3) chk(ovf_tx_data, (i == 1) ? 8'h01 : 8'ha3);
        end
    endtask : t_ovf

    task automatic t_width;
        int o0;
        ovf_len = dpc_pkg::DPC_OVF_BYTE;
        start_value = 32'h1234_00fe;
        end_value = 32'h0000_00ff;
        step_size = 8'h03;
        reload();
        chk(count_value, 32'hfe);
        o0 = ovf_seen;
        click();
        chk(count_value, 32'hfe);
        chk(ovf_seen - o0, 32'h1);
        count_size = dpc_pkg::DPC_SIZE_2B;
        end_value = 32'h0000_ffff;
        reload();
        chk(count_value, 32'h00fe);
        click();
        chk(count_value, 32'h0101);
    endtask : t_width

    // One second is 16 cycles here
    task automatic t_cyclic;
        int i;
        int c0;
        c0 = cyc_seen;
        cyc_enable = 1'b1;
        for (i = 0; i < 60 && cyc_seen == c0; i++) step(1);
        chk(count_tx_data, 32'h0101);
        c0 = cyc_seen;
        step(48);
        chk((cyc_seen - c0 >= 2) ? 32'h1 : 32'h0, 32'h1);
        cyc_period_s = 16'h0000;
        step(1);
        c0 = cyc_seen;
        step(60);
        chk(cyc_seen - c0, 32'h0);
        cyc_period_s = 16'h0001;
        cyc_enable = 1'b0;
        step(1);
        c0 = cyc_seen;
        step(60);
        chk(cyc_seen - c0, 32'h0);
    endtask : t_cyclic

    // Mid-run reset clears the count, then the start value returns
    task automatic t_reset;
        arst_n = 1'b0;
        step(2);
        chk(count_value, 32'h0);
        arst_n = 1'b1;
        step(3);
        chk(count_value, 32'h0000_00fe);
    endtask : t_reset

    initial begin
        step(8);
        arst_n = 1'b1;
        step(3);
        chk(count_value, 32'h3);
        t_edges();
        t_glitch_none();
        t_nc();
        t_ovf();
        t_width();
        t_cyclic();
        t_reset();
        tally_and_finish();
    end
endmodule : debounced_pulse_counter_input_test
